// ==== hw/sie_irq.sv ====
module sie_irq
(
    // Clock and reset.
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave.
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // Interrupt sources.
    input  wire sie_pkg::sie_src_type src_in,
    input  wire logic                timer2_overflow_event,
    input  wire logic                timer2_external_input,
    // Core side.
    input  wire logic                idle_enter,
    output logic                     core_irq_req,
    output logic                     core_wake,
    output logic                     core_idle,
    output logic                     irq
);
    logic [7:0]               interrupt_enable_mask_ff;
    logic [3:0]               phase_ff;
    logic [3:0]               t2ctl_ff;
    logic                     timer0_flag_ff;
    logic                     timer1_flag_ff;
    logic                     timer2_overflow_flag_ff;
    logic                     timer2_external_event_flag_ff;
    logic [5:0]               pend_ff;
    logic                     timer2_external_input_ff;
    logic                     core_irq_req_ff;
    logic                     core_wake_ff;
    logic                     core_idle_ff;
    logic [2:0]               status_ff;
    logic [2:0]               mask_ff;
    logic                     irq_ff;
    logic [31:0]              prdata_ff;
    logic                     pslverr_ff;
    sie_pkg::sie_core_state_type state_ff;
    logic                     wr;
    logic                     rd;
    logic                     t2_fall;
    logic                     exf_set;
    logic                     exf_toggle;
    logic [5:0]               live_src;
    logic                     nxt_req;
    logic [2:0]               ev;

    // Address match for one register on an access phase.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // Machine cycle phase counter, twelve clocks per machine cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_ff <= 4'h0;
        else if (phase_ff == sie_pkg::SIE_PHASE_LAST)
            phase_ff <= 4'h0;
        else
            phase_ff <= phase_ff + 4'h1;
    end

    // Enable register; bit 6 is reserved so it is never stored and reads as zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_enable_mask_ff <= sie_pkg::SIE_RST_ENABLE;
        else if (wr && hit(paddr, sie_pkg::SIE_OFF_ENABLE))
        begin
            interrupt_enable_mask_ff <= pwdata[7:0]; // RULE_04
            interrupt_enable_mask_ff[sie_pkg::SIE_BIT_RSVD] <= 1'b0; // RULE_05
        end
    end

    // Timer 2 mode bits: external trigger enable and up/down mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            t2ctl_ff <= sie_pkg::SIE_RST_T2CTL;
        else if (wr && hit(paddr, sie_pkg::SIE_OFF_T2CTL))
            t2ctl_ff <= {pwdata[sie_pkg::SIE_T2_UPDN], pwdata[sie_pkg::SIE_T2_EXEN], 2'b00};
    end

    // Falling edge detector on the timer 2 external input, which is taken as synchronous.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer2_external_input_ff <= 1'b1;
        else
            timer2_external_input_ff <= timer2_external_input;
    end
    assign t2_fall    = timer2_external_input_ff && !timer2_external_input && t2ctl_ff[sie_pkg::SIE_T2_EXEN];
    assign exf_set    = t2_fall && !t2ctl_ff[sie_pkg::SIE_T2_UPDN]; // RULE_11
    // The overflow event counts only at state 2 phase 2, so a twelve-clock pulse toggles once.
    assign exf_toggle = timer2_overflow_event && t2ctl_ff[sie_pkg::SIE_T2_UPDN]
        && phase_ff == sie_pkg::SIE_STATE2_PH2; // RULE_12

    // Timer 0 and 1 flags land at state 5 phase 2; hardware set wins over a software clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer0_flag_ff <= 1'b0;
            timer1_flag_ff <= 1'b0;
        end
        else
        begin
            if (src_in.timer0_overflow_flag && phase_ff == sie_pkg::SIE_STATE5_PH2)
                timer0_flag_ff <= 1'b1; // RULE_08
            else if (wr && hit(paddr, sie_pkg::SIE_OFF_T2CTL) && pwdata[4])
                timer0_flag_ff <= 1'b0;
            if (src_in.timer1_overflow_flag && phase_ff == sie_pkg::SIE_STATE5_PH2)
                timer1_flag_ff <= 1'b1; // RULE_08
            else if (wr && hit(paddr, sie_pkg::SIE_OFF_T2CTL) && pwdata[5])
                timer1_flag_ff <= 1'b0;
        end
    end

    // Timer 2 flags: vectoring never touches them; software clears both, and the up/down toggle can also clear the event flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer2_overflow_flag_ff       <= 1'b0;
            timer2_external_event_flag_ff <= 1'b0;
        end
        else
        begin
            if (timer2_overflow_event && phase_ff == sie_pkg::SIE_STATE2_PH2)
                timer2_overflow_flag_ff <= 1'b1; // RULE_09
            else if (wr && hit(paddr, sie_pkg::SIE_OFF_T2CTL) && !pwdata[sie_pkg::SIE_T2_OVF])
                timer2_overflow_flag_ff <= 1'b0; // RULE_07
            if (exf_set)
                timer2_external_event_flag_ff <= 1'b1;
            else if (exf_toggle)
                timer2_external_event_flag_ff <= !timer2_external_event_flag_ff;
            else if (wr && hit(paddr, sie_pkg::SIE_OFF_T2CTL) && !pwdata[sie_pkg::SIE_T2_EXF])
                timer2_external_event_flag_ff <= 1'b0; // RULE_07
        end
    end

    // Six gated sources in enable-register order; the event flag is ignored in up/down mode.
    assign live_src = {
        timer2_overflow_flag_ff | (timer2_external_event_flag_ff
            & ~t2ctl_ff[sie_pkg::SIE_T2_UPDN]), // RULE_06 RULE_12
        src_in.serial,
        timer1_flag_ff,
        src_in.ext1,
        timer0_flag_ff,
        src_in.ext0}; // RULE_01

    // Pending flags are polled at the poll phase, so timer 0 and 1 are seen one cycle late
    // while timer 2, set at state 2, is seen in its own machine cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_ff <= 6'h00;
        else if (phase_ff == sie_pkg::SIE_SAMPLE_PH)
            pend_ff <= live_src; // RULE_08 RULE_09
    end

    assign nxt_req = interrupt_enable_mask_ff[sie_pkg::SIE_BIT_GLOBAL] // RULE_03
        && |(pend_ff & interrupt_enable_mask_ff[5:0]); // RULE_02 RULE_13

    // Request to the core, registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_irq_req_ff <= 1'b0;
        else
            core_irq_req_ff <= nxt_req; // RULE_13
    end

    // Idle tracking; reset drops straight back to run.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff     <= sie_pkg::SIE_RUN; // RULE_10
            core_wake_ff <= 1'b0;
            core_idle_ff <= 1'b0;
        end
        else
        begin
            core_wake_ff <= 1'b0;
            case (state_ff)
                sie_pkg::SIE_RUN:
                    if (idle_enter)
                    begin
                        state_ff     <= sie_pkg::SIE_IDLE;
                        core_idle_ff <= 1'b1;
                    end
                sie_pkg::SIE_IDLE:
                    if (nxt_req)
                    begin
                        state_ff     <= sie_pkg::SIE_WAKE; // RULE_10
                        core_wake_ff <= 1'b1;
                        core_idle_ff <= 1'b0;
                    end
                sie_pkg::SIE_WAKE:
                    state_ff <= sie_pkg::SIE_RUN;
                default:
                begin
                    state_ff     <= sie_pkg::SIE_RUN;
                    core_idle_ff <= 1'b0;
                end
            endcase
        end
    end

    // Sticky status for the block's own interrupt; set wins over a write-one clear.
    assign ev = {exf_set, nxt_req && !core_irq_req_ff, core_wake_ff};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_ff <= sie_pkg::SIE_RST_IRQ;
        else if (wr && hit(paddr, sie_pkg::SIE_OFF_STATUS))
            status_ff <= (status_ff & ~pwdata[2:0]) | ev;
        else
            status_ff <= status_ff | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_ff <= sie_pkg::SIE_RST_IRQ;
        else if (wr && hit(paddr, sie_pkg::SIE_OFF_MASK))
            mask_ff <= pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status_ff & mask_ff);
    end

    // Read data and error answer; unmapped addresses answer with an error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_ff <= 1'b0;
            case (paddr)
                sie_pkg::SIE_OFF_ENABLE: prdata_ff <= {24'h000000, interrupt_enable_mask_ff};
                sie_pkg::SIE_OFF_STATUS: prdata_ff <= {29'h0, status_ff};
                sie_pkg::SIE_OFF_MASK:   prdata_ff <= {29'h0, mask_ff};
                sie_pkg::SIE_OFF_T2CTL:  prdata_ff <= {26'h0, timer1_flag_ff, timer0_flag_ff,
                                                       t2ctl_ff[3:2],
                                                       timer2_external_event_flag_ff,
                                                       timer2_overflow_flag_ff};
                sie_pkg::SIE_OFF_CORE:   prdata_ff <= {24'h0, pend_ff, core_irq_req_ff,
                                                       state_ff == sie_pkg::SIE_IDLE};
                default:
                begin
                    prdata_ff  <= 32'h0000_0000;
                    pslverr_ff <= 1'b1;
                end
            endcase
        end
    end

    assign pready       = 1'b1;
    assign prdata       = prdata_ff;
    assign pslverr      = pslverr_ff;
    assign core_irq_req = core_irq_req_ff;
    assign core_wake    = core_wake_ff;
    assign core_idle    = core_idle_ff;
    assign irq          = irq_ff;

    // Checks.
    property p_global_off;
        @(posedge pclk) disable iff (!presetn)
        !interrupt_enable_mask_ff[sie_pkg::SIE_BIT_GLOBAL] |=> !core_irq_req_ff;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request with global off"); // RULE_03

    property p_req_cause;
        @(posedge pclk) disable iff (!presetn)
        core_irq_req_ff |-> $past(|(pend_ff & interrupt_enable_mask_ff[5:0]));
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without cause"); // RULE_13

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        !interrupt_enable_mask_ff[sie_pkg::SIE_BIT_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit stored"); // RULE_05

    property p_t2_hold;
        @(posedge pclk) disable iff (!presetn)
        timer2_overflow_flag_ff && !wr |=> timer2_overflow_flag_ff;
    endproperty
    a_t2_hold: assert property (p_t2_hold) else $error("timer 2 flag lost"); // RULE_07

    property p_t0_phase;
        @(posedge pclk) disable iff (!presetn)
        $rose(timer0_flag_ff) |-> $past(phase_ff) == sie_pkg::SIE_STATE5_PH2;
    endproperty
    a_t0_phase: assert property (p_t0_phase) else $error("timer 0 flag off phase"); // RULE_08

    property p_t2_phase;
        @(posedge pclk) disable iff (!presetn)
        $rose(timer2_overflow_flag_ff) |-> ##[1:8] pend_ff[sie_pkg::SIE_BIT_T2];
    endproperty
    a_t2_phase: assert property (p_t2_phase) else $error("timer 2 not polled"); // RULE_09

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        state_ff == sie_pkg::SIE_IDLE && nxt_req |=> core_wake_ff ##1 !core_wake_ff;
    endproperty
    a_wake: assert property (p_wake) else $error("idle not ended"); // RULE_10

    property p_exf_set;
        @(posedge pclk) disable iff (!presetn)
        exf_set |=> timer2_external_event_flag_ff;
    endproperty
    a_exf_set: assert property (p_exf_set) else $error("event flag not set"); // RULE_11

    property p_t0_poll;
        @(posedge pclk) disable iff (!presetn)
        $rose(timer0_flag_ff) && !pend_ff[sie_pkg::SIE_BIT_T0]
            |-> !pend_ff[sie_pkg::SIE_BIT_T0] [*8] ##4 pend_ff[sie_pkg::SIE_BIT_T0];
    endproperty
    a_t0_poll: assert property (p_t0_poll) else $error("timer 0 polled off cycle"); // RULE_08

    property p_none_enabled;
        @(posedge pclk) disable iff (!presetn)
        interrupt_enable_mask_ff[5:0] == 6'h00 |=> !core_irq_req_ff;
    endproperty
    a_none_enabled: assert property (p_none_enabled) else $error("request with no enable"); // RULE_02

    property p_exf_hold;
        @(posedge pclk) disable iff (!presetn)
        timer2_external_event_flag_ff && !wr && !exf_toggle |=> timer2_external_event_flag_ff;
    endproperty
    a_exf_hold: assert property (p_exf_hold) else $error("event flag lost"); // RULE_07
endmodule

// ==== hw/sie_pkg.sv ====
// Notes on behaviour
// RULE_01 - Six interrupt sources exist: two external pins, three timer flags and the serial port.
// RULE_02 - Each source has its own enable bit; one lets it request service, zero blocks it.
// RULE_03 - The global enable in bit 7 of the enable register, when clear, blocks every interrupt; exf_set still reaches irq through status.
// RULE_04 - Enable bits 5 down to 0 are timer 2, serial, timer 1, external 1, timer 0, external 0.
// RULE_05 - Software must not write ones to reserved bit 6 of the enable register.
// RULE_06 - The timer 2 request is the OR of its overflow flag and its external event flag.
// RULE_07 - Vectoring leaves both timer 2 flags set; only a software write clears them. The up/down toggle here also clears the event flag.
// RULE_08 - Timer 0 and 1 flags are set at state 5 phase 2 and sampled in the next machine cycle.
// RULE_09 - The timer 2 overflow flag is set at state 2 phase 2 and sampled in the same cycle.
// RULE_10 - Any enabled request ends idle mode, and a hardware reset ends idle too.
// RULE_11 - In capture mode with external trigger, a falling edge on the timer 2 input sets its event flag.
// RULE_12 - In up/down reload mode the event flag toggles as a count bit and raises no request.
// RULE_13 - The core request is the global enable AND the OR of each pending flag AND its enable.
package sie_pkg;
    // Register byte offsets.
    localparam logic [7:0] SIE_OFF_ENABLE = 8'h00;
    localparam logic [7:0] SIE_OFF_STATUS = 8'h04;
    localparam logic [7:0] SIE_OFF_MASK   = 8'h08;
    localparam logic [7:0] SIE_OFF_T2CTL  = 8'h0c;
    localparam logic [7:0] SIE_OFF_CORE   = 8'h10;
    // Enable register field positions.
    localparam int SIE_BIT_EXT0   = 0;
    localparam int SIE_BIT_T0     = 1;
    localparam int SIE_BIT_EXT1   = 2;
    localparam int SIE_BIT_T1     = 3;
    localparam int SIE_BIT_SERIAL = 4;
    localparam int SIE_BIT_T2     = 5;
    localparam int SIE_BIT_RSVD   = 6;
    localparam int SIE_BIT_GLOBAL = 7;
    // Timer 2 control field positions.
    localparam int SIE_T2_OVF   = 0;
    localparam int SIE_T2_EXF   = 1;
    localparam int SIE_T2_EXEN  = 2;
    localparam int SIE_T2_UPDN  = 3;
    // Reset values.
    localparam logic [7:0] SIE_RST_ENABLE = 8'h00;
    localparam logic [3:0] SIE_RST_T2CTL  = 4'h0;
    localparam logic [2:0] SIE_RST_IRQ    = 3'h0;
    // Machine cycle: twelve clocks, six states of two phases; state5 phase2 and state2 phase2.
    localparam logic [3:0] SIE_PHASE_LAST  = 4'hb;
    localparam logic [3:0] SIE_STATE5_PH2  = 4'h9;
    localparam logic [3:0] SIE_STATE2_PH2  = 4'h3;
    // Poll at state 5 phase 1: timer 2 (set at state 2) is seen in its own cycle, while
    // timer 0 and 1 (set at state 5 phase 2) just miss it and are seen one cycle later.
    localparam logic [3:0] SIE_SAMPLE_PH   = 4'h8;
    // Status and mask bits of the block's own interrupt.
    localparam int SIE_EV_WAKE = 0;
    localparam int SIE_EV_REQ  = 1;
    localparam int SIE_EV_EXF  = 2;

    typedef enum logic [1:0] {
        SIE_RUN   = 2'b00,
        SIE_IDLE  = 2'b01,
        SIE_WAKE  = 2'b11
    } sie_core_state_type;

    typedef struct packed {
        logic ext0;
        logic ext1;
        logic timer0_overflow_flag;
        logic timer1_overflow_flag;
        logic serial;
    } sie_src_type;
endpackage

// ==== dv/sie_core_model.sv ====
// Core partner: puts itself to sleep on command and counts wake pulses.
module sie_core_model
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Block side.
    input  wire logic        core_irq_req,
    input  wire logic        core_wake,
    input  wire logic        core_idle,
    output logic             idle_enter,
    // Bench side.
    input  wire logic        sleep_cmd,
    output int               wakes
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle entry is one pulse; a core already asleep asks for nothing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_enter <= 1'b0;
        else
            idle_enter <= sleep_cmd & ~core_idle;
    end

    // Vectoring only counts wakes and never touches the flags.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wakes <= 0;
        else if (core_wake === 1'b1 && core_irq_req === 1'b1)
            wakes <= wakes + 1;
    end
endmodule

// ==== dv/test_sie_irq.sv ====
// Register-level tests of the interrupt enable logic.
module test_sie_irq;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    sie_pkg::sie_src_type src_in = '0;
    logic                 t2_ovf = 1'b0;
    logic                 t2_ext = 1'b1;
    logic                 idle_enter;
    logic                 core_irq_req;
    logic                 core_wake;
    logic                 core_idle;
    logic                 irq;
    logic                 sleep_cmd = 1'b0;
    int                   wakes;
    int                   mismatches = 0;
    int                   total_checks = 0;
    logic [31:0]          rd;
    logic                 er;
    // Source pattern for enable bits 0 to 4.
    logic [4:0]           src_tab [5] = '{5'h10, 5'h04, 5'h08, 5'h02, 5'h01};

    always #12.5 pclk = ~pclk;

    sie_irq i_sie_irq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .src_in(src_in), .timer2_overflow_event(t2_ovf),
        .timer2_external_input(t2_ext), .idle_enter(idle_enter),
        .core_irq_req(core_irq_req), .core_wake(core_wake), .core_idle(core_idle), .irq(irq));

    sie_core_model i_sie_core_model (.pclk(pclk), .presetn(presetn),
        .core_irq_req(core_irq_req), .core_wake(core_wake), .core_idle(core_idle),
        .idle_enter(idle_enter), .sleep_cmd(sleep_cmd), .wakes(wakes));

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits a bounded time for the core request to reach a level, then compares.
    task automatic wait_req(input logic exp, input string msg);
        for (int n = 0; n < 40 && core_irq_req !== exp; n++)
            @(posedge pclk);
        chk(core_irq_req, exp, msg);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic pulse_ovf();
        // Twelve clocks cover exactly one counting phase of the machine cycle.
        @(posedge pclk) t2_ovf <= 1'b1;
        cycles(12);
        t2_ovf <= 1'b0;
    endtask

    task automatic sleep();
        @(posedge pclk) sleep_cmd <= 1'b1;
        @(posedge pclk) sleep_cmd <= 1'b0;
        cycles(3);
    endtask

    initial
    begin
        #500000;
        mismatches++;
        test_done();
    end

    initial
    begin
        cycles(10);
        presetn <= 1'b1;
        apb(0, sie_pkg::SIE_OFF_ENABLE, 0);
        chk(rd, 32'h0, "enable reset");
        apb(0, 8'h40, 0);
        chk(er, 1'b1, "unmapped slverr");
        apb(1, sie_pkg::SIE_OFF_ENABLE, 32'hbf);
        apb(0, sie_pkg::SIE_OFF_ENABLE, 0);
        chk(rd, 32'hbf, "enable readback");
        for (int b = 0; b < 5; b++)
        begin
            apb(1, sie_pkg::SIE_OFF_ENABLE, 32'hbf ^ (32'h1 << b));
            @(posedge pclk) src_in <= src_tab[b];
            cycles(30);
            chk(core_irq_req, 1'b0, "disabled source");
            apb(1, sie_pkg::SIE_OFF_ENABLE, 32'h80 | (32'h1 << b));
            wait_req(1'b1, "enabled source");
            apb(1, sie_pkg::SIE_OFF_ENABLE, 32'h01 << b);
            wait_req(1'b0, "global off");
            apb(1, sie_pkg::SIE_OFF_ENABLE, 32'h80 | (32'h1 << b));
            @(posedge pclk) src_in <= '0;
            apb(1, sie_pkg::SIE_OFF_T2CTL, 32'h30);
            wait_req(1'b0, "source gone");
        end
        // Idle and wake, then the status and mask interrupt.
        apb(1, sie_pkg::SIE_OFF_ENABLE, 32'h0);
        apb(1, sie_pkg::SIE_OFF_STATUS, 32'h7);
        apb(1, sie_pkg::SIE_OFF_MASK, 32'h0);
        sleep();
        chk(core_idle, 1'b1, "idle entered");
        @(posedge pclk) src_in <= 5'h10;
        cycles(30);
        chk(core_idle, 1'b1, "woken by disabled");
        apb(1, sie_pkg::SIE_OFF_ENABLE, 32'h81);
        wait_req(1'b1, "wake request");
        cycles(2);
        chk(core_idle, 1'b0, "idle ended");
        chk(wakes, 1, "wake pulses");
        apb(0, sie_pkg::SIE_OFF_CORE, 0);
        chk(rd & 32'h3, 32'h2, "core reg");
        apb(0, sie_pkg::SIE_OFF_STATUS, 0);
        chk(rd, 32'h3, "status events");
        chk(irq, 1'b0, "irq masked");
        apb(1, sie_pkg::SIE_OFF_MASK, 32'h1);
        cycles(2);
        chk(irq, 1'b1, "irq unmasked");
        apb(1, sie_pkg::SIE_OFF_STATUS, 32'h1);
        cycles(2);
        chk(irq, 1'b0, "irq cleared");
        apb(0, sie_pkg::SIE_OFF_STATUS, 0);
        chk(rd, 32'h2, "w1c other bit");
        @(posedge pclk) src_in <= '0;
        // Timer 2 overflow flag holds until software clears it.
        apb(1, sie_pkg::SIE_OFF_ENABLE, 32'ha0);
        pulse_ovf();
        wait_req(1'b1, "t2 overflow req");
        cycles(24);
        apb(0, sie_pkg::SIE_OFF_T2CTL, 0);
        chk(rd & 32'h3, 32'h1, "t2 flag kept");
        apb(1, sie_pkg::SIE_OFF_T2CTL, 32'h0);
        wait_req(1'b0, "t2 flag cleared");
        // Falling edge on the external input in capture mode.
        apb(1, sie_pkg::SIE_OFF_T2CTL, 32'h4);
        @(posedge pclk) t2_ext <= 1'b0;
        wait_req(1'b1, "event req");
        apb(0, sie_pkg::SIE_OFF_T2CTL, 0);
        chk(rd & 32'h3, 32'h2, "event flag");
        apb(0, sie_pkg::SIE_OFF_STATUS, 0);
        chk(rd & 32'h4, 32'h4, "event status");
        apb(1, sie_pkg::SIE_OFF_T2CTL, 32'h4);
        wait_req(1'b0, "event cleared");
        @(posedge pclk) t2_ext <= 1'b1;
        // Up/down mode: the event flag counts but never requests.
        apb(1, sie_pkg::SIE_OFF_T2CTL, 32'h8);
        pulse_ovf();
        cycles(12);
        apb(0, sie_pkg::SIE_OFF_T2CTL, 0);
        chk(rd & 32'h3, 32'h3, "updn toggle");
        apb(1, sie_pkg::SIE_OFF_T2CTL, 32'ha);
        cycles(30);
        chk(core_irq_req, 1'b0, "updn no req");
        // A hardware reset ends idle.
        sleep();
        chk(core_idle, 1'b1, "idle again");
        @(posedge pclk) presetn <= 1'b0;
        cycles(2);
        presetn <= 1'b1;
        chk(core_idle, 1'b0, "reset ends idle");
        apb(0, sie_pkg::SIE_OFF_ENABLE, 0);
        chk(rd, 32'h0, "enable after reset");
        test_done();
    end
endmodule
